// >>> flash_core.sv
`timescale 1ns/1ns
`default_nettype none
module flash_core
  import flash_pkg::*;
#(
  parameter int MEM_AW = 12,
  parameter int OP_CYCLES = 64
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // burst read pins
  input wire logic address_valid_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [1:0] burst_mode_i,
  input wire logic burst_stop_i,
  output logic [WORD_W-1:0] data_o,
  output logic data_oe_n_o,
  output logic ready_o,
  // program and erase port
  input wire logic [1:0] op_i,
  input wire logic [ADDR_W-1:0] op_addr_i,
  input wire logic [WORD_W-1:0] op_data_i,
  output logic op_busy_o,
  output logic [3:0] busy_bank_o,
  output logic op_reject_o
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic avd_s1_q, avd_s2_q;
  logic stop_s1_q, stop_s2_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avd_s1_q <= 1'b1;
      avd_s2_q <= 1'b1;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else if (ce_i) begin
      avd_s1_q <= address_valid_n_i;
      avd_s2_q <= avd_s1_q;
      stop_s1_q <= burst_stop_i;
      stop_s2_q <= stop_s1_q;
    end
  end
  function automatic logic [3:0] bank_of(input logic [ADDR_W-1:0] a);
    bank_of = a[BANK_LSB +: 4];
  endfunction

  // --------------------------------------------------------------
  // burst engine
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    B_IDLE, B_WAIT, B_DATA, B_FETCH, B_BLOCK
  } burst_e;
  burst_e bst_q, bst_d;
  logic [ADDR_W-1:0] baddr_q, baddr_d;
  logic [1:0] bmode_q, bmode_d;
  logic [4:0] left_q, left_d;
  logic [2:0] wcnt_q, wcnt_d;
  logic [WORD_W-1:0] data_d;
  logic oe_n_d, rdy_d;
  logic [WORD_W-1:0] rd_word;
  logic [MEM_AW-1:0] rd_addr;
  logic op_active_q;
  logic [3:0] op_bank_q;
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a, input logic [1:0] m);
    logic [ADDR_W-1:0] n;
    n = a + ADDR_W'(1);
    if (m == BURST_WRAP8) begin
      n = {a[ADDR_W-1:3], 3'(a[2:0] + 3'h1)};
    end else if (m == BURST_WRAP16) begin
      n = {a[ADDR_W-1:4], 4'(a[3:0] + 4'h1)};
    end
    next_addr = n;
  endfunction
  always_comb begin
    bst_d = bst_q;
    baddr_d = baddr_q;
    bmode_d = bmode_q;
    left_d = left_q;
    wcnt_d = wcnt_q;
    data_d = data_o;
    oe_n_d = data_oe_n_o;
    rdy_d = ready_o;
    case (bst_q)
      B_IDLE: begin
        oe_n_d = 1'b1;
        rdy_d = 1'b0;
      end
      B_WAIT: begin
        rdy_d = 1'b0;
        if (wcnt_q == 3'h0) begin
          bst_d = B_DATA;
        end else begin
          wcnt_d = wcnt_q - 3'h1;
        end
      end
      B_DATA: begin
        data_d = rd_word;
        oe_n_d = 1'b0;
        rdy_d = 1'b1;
        baddr_d = next_addr(baddr_q, bmode_q);
        if (bmode_q != BURST_CONT) begin
          left_d = left_q - 5'h1;
          if (left_q == 5'h1) begin
            bst_d = B_IDLE;
          end
        end else if (baddr_q[3:0] == 4'hF) begin
          wcnt_d = 3'(FETCH_WAIT);
          bst_d = B_FETCH;
        end
        if (op_active_q &&
            bank_of(next_addr(baddr_q, bmode_q)) == op_bank_q) begin
          bst_d = B_BLOCK;
        end
      end
      B_FETCH: begin
        rdy_d = 1'b0;
        if (wcnt_q == 3'h0) begin
          bst_d = B_DATA;
        end else begin
          wcnt_d = wcnt_q - 3'h1;
        end
      end
      B_BLOCK: begin
        // busy bank gives no valid data, so hold ready low
        rdy_d = 1'b0;
        if (!(op_active_q && bank_of(baddr_q) == op_bank_q)) begin
          bst_d = B_DATA;
        end
      end
      default: bst_d = B_IDLE;
    endcase
    if (stop_s2_q && bst_q != B_IDLE) begin
      bst_d = B_IDLE;
    end
    if (!avd_s2_q) begin
      baddr_d = addr_i;
      bmode_d = burst_mode_i;
      left_d = (burst_mode_i == BURST_WRAP8) ? 5'h08 : 5'h10;
      wcnt_d = 3'(FIRST_WAIT);
      rdy_d = 1'b0;
      bst_d = (op_active_q && bank_of(addr_i) == op_bank_q) ? B_BLOCK
            : B_WAIT;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bst_q <= B_IDLE;
      baddr_q <= '0;
      bmode_q <= BURST_CONT;
      left_q <= 5'h00;
      wcnt_q <= 3'h0;
      data_o <= DATA_RST;
      data_oe_n_o <= 1'b1;
      ready_o <= 1'b0;
    end else if (ce_i) begin
      bst_q <= bst_d;
      baddr_q <= baddr_d;
      bmode_q <= bmode_d;
      left_q <= left_d;
      wcnt_q <= wcnt_d;
      data_o <= data_d;
      data_oe_n_o <= oe_n_d;
      ready_o <= rdy_d;
    end
  end

  // --------------------------------------------------------------
  // program and erase engine
  // --------------------------------------------------------------
  // model holds one page buffer and one small array window; the
  // window trades full capacity for a synthesizable size
  typedef enum logic [1:0] {P_IDLE, P_PROG, P_ERASE} prog_e;
  prog_e pst_q, pst_d;
  logic [WORD_W-1:0] pbuf_q [0:PAGE_WORDS-1];
  logic [WORD_W-1:0] pbuf_d [0:PAGE_WORDS-1];
  logic [PAGE_WORDS-1:0] pvalid_q, pvalid_d;
  logic [ADDR_W-1:0] paddr_q, paddr_d;
  logic [16:0] pidx_q, pidx_d;
  logic [15:0] tmr_q, tmr_d;
  logic op_active_d;
  logic [3:0] op_bank_d;
  logic reject_d;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic [MEM_AW-1:0] rmw_addr;
  always_comb begin
    pst_d = pst_q;
    pbuf_d = pbuf_q;
    pvalid_d = pvalid_q;
    paddr_d = paddr_q;
    pidx_d = pidx_q;
    tmr_d = tmr_q;
    op_active_d = op_active_q;
    op_bank_d = op_bank_q;
    reject_d = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = ERASED_WORD;
    case (pst_q)
      P_IDLE: begin
        if (op_i == OP_LOAD) begin
          if (pvalid_q == '0) begin
            paddr_d = op_addr_i;
          end
          if (op_addr_i[ADDR_W-1:8] != paddr_d[ADDR_W-1:8]) begin
            reject_d = 1'b1;
          end else begin
            pbuf_d[op_addr_i[7:0]] = op_data_i;
            pvalid_d[op_addr_i[7:0]] = 1'b1;
          end
        end else if (op_i == OP_PROG && pvalid_q != '0) begin
          pst_d = P_PROG;
          pidx_d = '0;
          tmr_d = 16'(OP_CYCLES);
          op_active_d = 1'b1;
          op_bank_d = bank_of(paddr_q);
        end else if (op_i == OP_ERASE) begin
          pst_d = P_ERASE;
          paddr_d = {op_addr_i[ADDR_W-1:16], 16'h0000};
          pidx_d = '0;
          tmr_d = 16'(OP_CYCLES);
          op_active_d = 1'b1;
          op_bank_d = bank_of(op_addr_i);
        end
      end
      P_PROG: begin
        // one word per cycle, read-modify-write on the window
        if (pidx_q[8] == 1'b0) begin
          if (pvalid_q[pidx_q[7:0]]) begin
            mem_we = 1'b1;
            mem_waddr = MEM_AW'({paddr_q[ADDR_W-1:8], pidx_q[7:0]});
            // zeros only: AND keeps cleared bits cleared
            mem_wdata = rd_word & pbuf_q[pidx_q[7:0]];
          end
          pidx_d = pidx_q + 17'h1;
        end else if (tmr_q != 16'h0) begin
          tmr_d = tmr_q - 16'h1;
        end else begin
          pst_d = P_IDLE;
          pvalid_d = '0;
          op_active_d = 1'b0;
        end
      end
      P_ERASE: begin
        if (pidx_q < 17'(SECTOR_WORDS) && pidx_q < 17'(1 << MEM_AW)) begin
          mem_we = 1'b1;
          mem_waddr = MEM_AW'(pidx_q);
          mem_wdata = ERASED_WORD;
          pidx_d = pidx_q + 17'h1;
        end else if (tmr_q != 16'h0) begin
          tmr_d = tmr_q - 16'h1;
        end else begin
          pst_d = P_IDLE;
          op_active_d = 1'b0;
        end
      end
      default: pst_d = P_IDLE;
    endcase
    if (op_i != OP_NONE && pst_q != P_IDLE) begin
      reject_d = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pst_q <= P_IDLE;
      pvalid_q <= '0;
      paddr_q <= '0;
      pidx_q <= '0;
      tmr_q <= 16'h0;
      op_active_q <= 1'b0;
      op_bank_q <= 4'h0;
      op_busy_o <= 1'b0;
      busy_bank_o <= 4'h0;
      op_reject_o <= 1'b0;
    end else if (ce_i) begin
      pst_q <= pst_d;
      pvalid_q <= pvalid_d;
      paddr_q <= paddr_d;
      pidx_q <= pidx_d;
      tmr_q <= tmr_d;
      op_active_q <= op_active_d;
      op_bank_q <= op_bank_d;
      op_busy_o <= op_active_d;
      busy_bank_o <= op_bank_d;
      op_reject_o <= reject_d;
      pbuf_q <= pbuf_d;
    end
  end

  // --------------------------------------------------------------
  // array window
  // --------------------------------------------------------------
  // next program word fetched a cycle ahead for the AND, from the start
  // cycle on; one read port, so bursts during a program see its words
  assign rmw_addr = MEM_AW'({paddr_q[ADDR_W-1:8], pidx_d[7:0]});
  assign rd_addr = (pst_d == P_PROG) ? rmw_addr : MEM_AW'(baddr_d);
  flash_array #(
    .AW(MEM_AW),
    .DW(WORD_W)
  ) u_array (
    .clk_i(sys_clk_i),
    .en_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(rd_addr),
    .rdata_o(rd_word)
  );

endmodule
`default_nettype wire

// >>> flash_pkg.sv
package flash_pkg;

  // --------------------------------------------------------------
  // geometry
  // --------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int NUM_BANKS = 16;
  localparam int BANK_BYTES_MB = 8;
  localparam int SECTOR_BYTES = 131072;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_WORDS = PAGE_BYTES / 2;
  localparam int SECTOR_WORDS = SECTOR_BYTES / 2;
  localparam int GROUP_WORDS = 16;
  localparam int ADDR_W = 26;
  localparam int BANK_LSB = 22;

  // --------------------------------------------------------------
  // burst modes and commands
  // --------------------------------------------------------------
  localparam logic [1:0] BURST_CONT = 2'h0;
  localparam logic [1:0] BURST_WRAP8 = 2'h1;
  localparam logic [1:0] BURST_WRAP16 = 2'h2;

  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_LOAD = 2'h1;
  localparam logic [1:0] OP_PROG = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // --------------------------------------------------------------
  // timing and reset values
  // --------------------------------------------------------------
  localparam int FETCH_WAIT = 3;
  localparam int FIRST_WAIT = 2;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;

endpackage

// >>> flash_array.sv
`timescale 1ns/1ns
`default_nettype none
module flash_array
  import flash_pkg::*;
#(
  parameter int AW = 12,
  parameter int DW = WORD_W
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  // model array starts erased; registered read port
  logic [DW-1:0] mem [0:(1<<AW)-1];
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = ERASED_WORD;
    end
  end
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// >>> flash_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module flash_core_assertions
  import flash_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic address_valid_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic burst_stop_i,
  input wire logic [1:0] op_i,
  input wire logic [ADDR_W-1:0] op_addr_i,
  input wire logic ready_o,
  input wire logic data_oe_n_o,
  input wire logic op_busy_o,
  input wire logic [3:0] busy_bank_o,
  input wire logic op_reject_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  rst_quiet_a: assert property (disable iff (1'b0) rst_i |=>
    !ready_o && data_oe_n_o && !op_busy_o) else $error("reset state");
  ready_driven_a: assert property (ready_o |-> !data_oe_n_o)
    else $error("ready without drive");
  first_word_a: assert property ($fell(address_valid_n_i) &&
    !(op_busy_o && busy_bank_o == addr_i[BANK_LSB +: 4]) |->
    !ready_o [*3] ##[1:12] ready_o) else $error("first word late");
  stop_ends_a: assert property ($rose(burst_stop_i) |->
    ##6 !ready_o [*4]) else $error("burst not ended");
  erase_start_a: assert property ((op_i == OP_ERASE) && !op_busy_o
    |=> op_busy_o) else $error("erase not started");
  busy_refuse_a: assert property (op_busy_o && (op_i != OP_NONE)
    |=> op_reject_o) else $error("op not refused");
  reject_pulse_a: assert property (op_reject_o |=> !op_reject_o)
    else $error("reject too long");
  busy_bank_a: assert property ($rose(op_busy_o) |->
    busy_bank_o == 4'($past(op_addr_i) >> BANK_LSB))
    else $error("wrong busy bank");

  cover property ($rose(ready_o));
  cover property (op_reject_o);
  cover property (op_busy_o && ready_o);
endmodule

bind flash_core flash_core_assertions flash_core_assertions_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .address_valid_n_i(address_valid_n_i), .addr_i(addr_i),
  .burst_stop_i(burst_stop_i),
  .op_i(op_i), .op_addr_i(op_addr_i), .ready_o(ready_o),
  .data_oe_n_o(data_oe_n_o), .op_busy_o(op_busy_o),
  .busy_bank_o(busy_bank_o), .op_reject_o(op_reject_o)
);
`default_nettype wire

// >>> flash_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host_model
  import flash_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [WORD_W-1:0] data_i,
  output logic address_valid_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [1:0] mode_o,
  output logic stop_o
);
  // ----
  // burst reader
  // ----
  logic [WORD_W-1:0] words [$];
  int gap_max;
  initial begin
    address_valid_n_o = 1'b1;
    addr_o = '0;
    mode_o = BURST_CONT;
    stop_o = 1'b0;
  end
  task automatic burst(input logic [ADDR_W-1:0] a, input logic [1:0] m,
                       input int n);
    int g;
    int w;
    words = {};
    gap_max = 0;
    g = 0;
    w = 0;
    @(posedge clk_i);
    #1;
    address_valid_n_o = 1'b0;
    addr_o = a;
    mode_o = m;
    repeat (3) @(posedge clk_i);
    #1;
    address_valid_n_o = 1'b1;
    while (words.size() < n && w < 80) begin
      // look just after the edge, once the registered outputs settle
      @(posedge clk_i);
      #1;
      w++;
      // words only count with ready high
      if (ready_i === 1'b1) begin
        if (words.size() > 0 && g > gap_max) gap_max = g;
        words.push_back(data_i);
        g = 0;
      end else g++;
    end
    addr_o = ~a; // released bus must not look valid
    stop_o = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    stop_o = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> tb_flash_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flash_core;
  import flash_pkg::*;
  logic sys_clk_i, rst_i, ce_i, avn, stop, oe_n, rdy, busy, rej;
  logic [ADDR_W-1:0] addr, op_addr;
  logic [1:0] mode, op;
  logic [WORD_W-1:0] data, op_data;
  logic [3:0] bank;
  int fails, n_compared;
  flash_core #(.OP_CYCLES(64)) flash_core_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .address_valid_n_i(avn), .addr_i(addr),
    .burst_mode_i(mode), .burst_stop_i(stop), .data_o(data),
    .data_oe_n_o(oe_n), .ready_o(rdy), .op_i(op), .op_addr_i(op_addr),
    .op_data_i(op_data), .op_busy_o(busy), .busy_bank_o(bank),
    .op_reject_o(rej));
  flash_host_model flash_host_model_i (.clk_i(sys_clk_i), .ready_i(rdy),
    .data_i(data), .address_valid_n_o(avn), .addr_o(addr), .mode_o(mode),
    .stop_o(stop));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] pat(input int i);
    return {8'hA5, 8'(i)};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_op(input logic [1:0] o, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d);
    @(posedge sys_clk_i);
    #1;
    op = o;
    op_addr = a;
    op_data = d;
    @(posedge sys_clk_i);
    #1;
    op = OP_NONE;
  endtask
  task automatic wait_idle();
    // a sector erase runs one word per cycle through the window
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    check("idle", busy, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  task automatic t_erase();
    do_op(OP_ERASE, '0, '0);
    check("erase busy", busy, 1'b1);
    wait_idle();
    flash_host_model_i.burst(26'h000000E, BURST_CONT, 4);
    for (int i = 0; i < 4; i++)
      check("erased", flash_host_model_i.words[i], ERASED_WORD);
    check("gap", flash_host_model_i.gap_max, FETCH_WAIT + 1);
    $display("test erase done");
  endtask
  task automatic t_prog();
    for (int i = 0; i < 32; i++) do_op(OP_LOAD, ADDR_W'(i), pat(i));
    do_op(OP_LOAD, 26'h0000100, 16'h0000);
    check("page", rej, 1'b1);
    do_op(OP_PROG, '0, '0);
    check("prog busy", busy, 1'b1);
    do_op(OP_ERASE, '0, '0);
    check("refused", rej, 1'b1);
    wait_idle();
    $display("test program done");
  endtask
  task automatic t_bursts();
    flash_host_model_i.burst(26'h0000005, BURST_WRAP8, 8);
    for (int i = 0; i < 8; i++)
      check("wrap8", flash_host_model_i.words[i], pat((5 + i) % 8));
    flash_host_model_i.burst(26'h000001B, BURST_WRAP16, 16);
    for (int i = 0; i < 16; i++)
      check("wrap16", flash_host_model_i.words[i],
            pat(16 + (11 + i) % 16));
    flash_host_model_i.burst(26'h000000E, BURST_CONT, 4);
    for (int i = 0; i < 4; i++)
      check("cont", flash_host_model_i.words[i], pat(14 + i));
    check("cont gap", flash_host_model_i.gap_max, FETCH_WAIT + 1);
    $display("test bursts done");
  endtask
  task automatic t_reprog();
    do_op(OP_LOAD, '0, 16'h0F0F);
    do_op(OP_LOAD, 26'h0000001, 16'hFFFF);
    do_op(OP_PROG, '0, '0);
    wait_idle();
    flash_host_model_i.burst('0, BURST_WRAP8, 2);
    check("clear", flash_host_model_i.words[0], 16'h0500);
    check("keep", flash_host_model_i.words[1], pat(1));
    $display("test reprogram done");
  endtask
  task automatic t_rww();
    do_op(OP_ERASE, 26'h0400000, '0);
    check("bank", bank, 4'h1);
    flash_host_model_i.burst(26'h0000008, BURST_WRAP8, 8);
    check("rww", flash_host_model_i.words.size(), 8);
    // the busy bank itself gives no word while the erase runs
    flash_host_model_i.burst(26'h0400010, BURST_WRAP8, 1);
    check("blocked", flash_host_model_i.words.size(), 0);
    wait_idle();
    $display("test read while busy done");
  endtask
  // ----
  // run
  // ----
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    report_and_stop();
  end
  initial begin
    fails = 0;
    n_compared = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    op = OP_NONE;
    op_addr = '0;
    op_data = '0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    t_prog();
    t_bursts();
    t_reprog();
    // erase after programming, so erased words differ from the data
    t_erase();
    t_rww();
    report_and_stop();
  end
endmodule
`default_nettype wire
